// ==== rtl/fault_mask_params.svh ====
/*
  Constants of the fault flag and fault pin mask block: register
  offsets, field positions, reset values, flag capture behaviour.
  Assumes one 100 MHz clock and that the serial bus engine presents
  register accesses on that clock.
*/
// Behaviour
// - ground-short flags at 0x1C, startup only
// - led_short_flags flags at 0x1D, read only
// - mask bit 4 blocks boost faults
// - mask bit 3 blocks open faults
// - mask bit 2 blocks ground-short faults
// - mask at 0x1E; bits 1,0 block
// - open flags per channel feed pin
// - boost undervoltage flag latches, boost class
// - boost overvoltage flag follows the limit
// - temperature warning flag follows the sensor
`ifndef FAULT_MASK_PARAMS_SVH
`define FAULT_MASK_PARAMS_SVH

// ****************************************
// register map
// ****************************************
`define FM_ADDR_GND_SHORT 8'h1C
`define FM_ADDR_LED_SHORT 8'h1D
`define FM_ADDR_PIN_MASK 8'h1E
`define FM_FLAGS_RESET 6'h00
`define FM_MASK_RESET 5'h00
`define FM_READ_IDLE 8'h00
`define FM_FLAG_PAD 2'h0
`define FM_MASK_PAD 3'h0

// ****************************************
// mask fields
// ****************************************
`define FM_MASK_BOOST 4
`define FM_MASK_OPEN 3
`define FM_MASK_GND 2
`define FM_MASK_TEMP 1
`define FM_MASK_LED 0
`define FM_MASK_MSB 4

// ****************************************
// capture: per-channel and undervoltage flags hold until reset
// ****************************************
`define FM_SRC_WIDTH 21
`define FM_STICKY_MASK 21'h1FFFFC
`define FM_SYNC_DEPTH 3

`endif

// ==== rtl/fault_mask_pkg.sv ====
/*
  Types shared by the fault flag block.
  Assumes fault_mask_params.svh for the widths.
*/
`include "fault_mask_params.svh"
package fault_mask_pkg;

  typedef struct packed {
    logic [5:0] groundShort;
    logic [5:0] ledShort;
    logic [5:0] openString;
    logic boostUndervoltage;
    logic boostOvervoltage;
    logic tempWarning;
  } fault_src_t;

  typedef struct packed {
    logic rdEn;
    logic wrEn;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage : fault_mask_pkg

// ==== rtl/fault_flag_capture.sv ====
/*
  Two-flop synchronisers and flag capture for the detector outputs.
  Assumes the detector levels are asynchronous to clk_sys.
*/
`timescale 1ns/10ps
module fault_flag_capture #(
  parameter int WIDTH = 21,
  parameter logic [WIDTH-1:0] STICKY = '0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] sense,
  input wire logic [WIDTH-1:0] captureEn,
  output logic [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1 <= '0;
      stage2 <= '0;
    end
    else
    begin
      stage1 <= sense;
      stage2 <= stage1;
    end
  end

  // sticky bits only ever set; level bits track the detector
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_flag
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
          flags[i] <= 1'b0;
        else if (STICKY[i])
          flags[i] <= flags[i] | (stage2[i] & captureEn[i]);
        else
          flags[i] <= stage2[i] & captureEn[i];
      end
    end
  endgenerate

endmodule : fault_flag_capture

// ==== rtl/led_fault_flags_and_pin_mask.sv ====
/*
  Fault flag registers, fault pin mask register and the open-drain
  fault pin drive. Assumes the serial bus engine on clk_sys gives one
  cycle read/write strobes and takes readData the cycle after rdEn.
*/
`timescale 1ns/10ps
`include "fault_mask_params.svh"
module led_fault_flags_and_pin_mask
  import fault_mask_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire reg_req_t regReq,
  input wire fault_src_t faultSense,
  input wire logic startupPhase,
  output logic [7:0] readData,
  output logic faultPinOut,
  output logic faultPinOe_n
);

  // ****************************************
  // flag capture
  // ****************************************
  fault_src_t flags;
  fault_src_t captureEn;
  logic [4:0] pinMask;
  logic startupMeta;
  logic startupSync;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      startupMeta <= 1'b0;
      startupSync <= 1'b0;
    end
    else
    begin
      startupMeta <= startupPhase;
      startupSync <= startupMeta;
    end
  end

  always_comb
  begin
    captureEn = '1;
    captureEn.groundShort = {6{startupSync}};
  end

  fault_flag_capture #(
    .WIDTH(`FM_SRC_WIDTH),
    .STICKY(`FM_STICKY_MASK)
  ) u_capture (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sense(faultSense),
    .captureEn(captureEn),
    .flags(flags)
  );

  // ****************************************
  // fault pin
  // ****************************************
  function automatic logic pinFault(input fault_src_t f,
                                    input logic [4:0] m);
    logic boostHit;
    boostHit = (f.boostUndervoltage | f.boostOvervoltage)
               & ~m[`FM_MASK_BOOST];
    pinFault = boostHit
      | ((|f.openString) & ~m[`FM_MASK_OPEN])
      | ((|f.groundShort) & ~m[`FM_MASK_GND])
      | (f.tempWarning & ~m[`FM_MASK_TEMP])
      | ((|f.ledShort) & ~m[`FM_MASK_LED]);
  endfunction : pinFault

  // value stays low; only the enable moves, so the pin is open drain
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      faultPinOut <= 1'b0;
      faultPinOe_n <= 1'b1;
    end
    else
    begin
      faultPinOut <= 1'b0;
      faultPinOe_n <= ~pinFault(flags, pinMask);
    end
  end

  // ****************************************
  // register file
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pinMask <= `FM_MASK_RESET;
    else if (regReq.wrEn && regReq.addr == `FM_ADDR_PIN_MASK)
      pinMask <= regReq.wdata[`FM_MASK_MSB:0];
  end

  // writes to flag offsets fall through: those registers are read only
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      readData <= `FM_READ_IDLE;
    else if (regReq.rdEn)
    begin
      unique case (regReq.addr)
        `FM_ADDR_GND_SHORT:
          readData <= {`FM_FLAG_PAD, flags.groundShort};
        `FM_ADDR_LED_SHORT:
          readData <= {`FM_FLAG_PAD, flags.ledShort};
        `FM_ADDR_PIN_MASK:
          readData <= {`FM_MASK_PAD, pinMask};
        default:
          readData <= `FM_READ_IDLE;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_gnd_readback: assert property (regReq.rdEn
    && regReq.addr == `FM_ADDR_GND_SHORT |=> readData ==
    {`FM_FLAG_PAD, $past(flags.groundShort)})
    else $error("ground short readback wrong");
  a_gnd_sticky: assert property ((($past(flags.groundShort)
    & ~flags.groundShort) == `FM_FLAGS_RESET))
    else $error("ground short flag cleared");
  a_led_readback: assert property (regReq.rdEn
    && regReq.addr == `FM_ADDR_LED_SHORT |=> readData ==
    {`FM_FLAG_PAD, $past(flags.ledShort)})
    else $error("led short readback wrong");
  // only boost flags may be up: a masked boost fault must leave pin free
  a_boost_blocked: assert property (pinMask[`FM_MASK_BOOST]
    && flags.groundShort == `FM_FLAGS_RESET
    && flags.ledShort == `FM_FLAGS_RESET
    && flags.openString == `FM_FLAGS_RESET
    && !flags.tempWarning |=> faultPinOe_n)
    else $error("masked boost fault drove pin");
  a_open_drives: assert property (!pinMask[`FM_MASK_OPEN]
    && (|flags.openString) |=> !faultPinOe_n)
    else $error("open fault did not drive pin");
  a_gnd_drives: assert property (!pinMask[`FM_MASK_GND]
    && (|flags.groundShort) |=> !faultPinOe_n)
    else $error("ground short did not drive pin");
  a_mask_write: assert property (regReq.wrEn
    && regReq.addr == `FM_ADDR_PIN_MASK |=> pinMask ==
    $past(regReq.wdata[`FM_MASK_MSB:0]))
    else $error("mask write lost");
  a_open_sticky: assert property ((($past(flags.openString)
    & ~flags.openString) == `FM_FLAGS_RESET))
    else $error("open flag cleared");
  a_uv_sticky: assert property ($past(flags.boostUndervoltage)
    |-> flags.boostUndervoltage)
    else $error("undervoltage flag cleared");
  // whole sync pipe must have run out of reset, else stale sense is seen
  a_ov_level: assert property ($past(rst_n) && $past(rst_n, 2)
    && $past(rst_n, `FM_SYNC_DEPTH) |-> flags.boostOvervoltage ==
    $past(faultSense.boostOvervoltage, `FM_SYNC_DEPTH))
    else $error("overvoltage flag not tracking");
  a_temp_level: assert property ($past(rst_n) && $past(rst_n, 2)
    && $past(rst_n, `FM_SYNC_DEPTH) |-> flags.tempWarning ==
    $past(faultSense.tempWarning, `FM_SYNC_DEPTH))
    else $error("temperature flag not tracking");
  a_pin_release: assert property (!pinFault(flags, pinMask)
    |=> faultPinOe_n && !faultPinOut)
    else $error("pin held without unmasked fault");

  c_pin_low: cover property (!faultPinOe_n);
  c_mask_write: cover property (regReq.wrEn
    && regReq.addr == `FM_ADDR_PIN_MASK);
  c_gnd_seen: cover property (regReq.rdEn
    && regReq.addr == `FM_ADDR_GND_SHORT && (|flags.groundShort));

endmodule : led_fault_flags_and_pin_mask

// ==== tb/fault_host_model.sv ====
/*
  Host side model: issues single-byte register strobes to the fault block.
  Assumes requests launch at the falling edge of clk_sys.
*/
`timescale 1ns/10ps
module fault_host_model
  import fault_mask_pkg::*;
(
  input wire logic clk_sys,
  output reg_req_t regReq,
  input wire logic [7:0] readData
);
  initial regReq = '0;

  // one strobe cycle; answer taken once the taking edge has landed
  task automatic access(input logic wr, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_sys);
    regReq = '{rdEn: !wr, wrEn: wr, addr: a, wdata: d};
    @(negedge clk_sys);
    regReq = '{rdEn: 1'b0, wrEn: 1'b0, addr: ~a, wdata: ~d};
    q = readData;
  endtask : access
endmodule : fault_host_model

// ==== tb/tb_led_fault_flags_and_pin_mask.sv ====
/*
  Self-checking bench for the fault flag and pin mask block.
  Assumes the host model drives the register strobes.
*/
`timescale 1ns/10ps
module tb_led_fault_flags_and_pin_mask
  import fault_mask_pkg::*;
;
  typedef struct packed {logic [20:0] sense; logic [2:0] maskBit;} row_t;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  reg_req_t regReq;
  fault_src_t faultSense = '0;
  logic startupPhase = 1'b1;
  logic [7:0] readData;
  logic faultPinOut;
  logic faultPinOe_n;
  logic [7:0] q;
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;
  // gnd, led, open, undervoltage, overvoltage, temperature
  row_t rows [6] = '{'{21'h108000, 3'h2}, '{21'h002400, 3'h0},
    '{21'h000010, 3'h3}, '{21'h4, 3'h4}, '{21'h2, 3'h4}, '{21'h1, 3'h1}};

  always #5 clk_sys = ~clk_sys;

  led_fault_flags_and_pin_mask u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .regReq(regReq), .faultSense(faultSense), .startupPhase(startupPhase),
    .readData(readData), .faultPinOut(faultPinOut),
    .faultPinOe_n(faultPinOe_n));
  fault_host_model u_host (.clk_sys(clk_sys), .regReq(regReq),
    .readData(readData));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.access(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    u_host.access(1'b0, a, 8'h00, q);
    check(q, exp);
  endtask : rd

  // sources cleared first: sticky flags only drop in reset
  task automatic doReset();
    @(negedge clk_sys);
    faultSense = '0;
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
  endtask : doReset

  // settle covers 2 sync flops, flag flop and pin flop
  task automatic pinIs(input logic exp);
    repeat (6) @(negedge clk_sys);
    check({7'h00, faultPinOe_n}, {7'h00, exp});
    check({7'h00, faultPinOut}, 8'h00);
  endtask : pinIs

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    for (int i = 0; i < 6; i++)
      for (int b = 0; b < 2; b++)
      begin
        doReset();
        wr(8'h1E, (8'h01 << rows[i].maskBit) & {8{b[0]}});
        faultSense = fault_src_t'(rows[i].sense);
        pinIs(b[0]);
        rd(8'h1C, {2'h0, faultSense.groundShort});
        rd(8'h1D, {2'h0, faultSense.ledShort});
        rd(8'h1E, (8'h01 << rows[i].maskBit) & {8{b[0]}});
        $display("row %0d blocked %0d done", i, b);
      end
    doReset();
    rd(8'h1C, 8'h00);
    rd(8'h1D, 8'h00);
    rd(8'h1E, 8'h00);
    wr(8'h1C, 8'hFF);
    wr(8'h1D, 8'hFF);
    rd(8'h1C, 8'h00);
    rd(8'h1D, 8'h00);
    wr(8'h1E, 8'hFF);
    rd(8'h1E, 8'h1F);
    rd(8'h1F, 8'h00);
    $display("reset and access test done");
    doReset();
    startupPhase = 1'b0;
    faultSense.groundShort = 6'h3F;
    pinIs(1'b1);
    rd(8'h1C, 8'h00);
    startupPhase = 1'b1;
    $display("startup window test done");
    for (int k = 1; k < 3; k++)
    begin
      doReset();
      faultSense = fault_src_t'(21'(k));
      pinIs(1'b0);
      faultSense = '0;
      pinIs(1'b1);
      faultSense = fault_src_t'(21'(k));
      pinIs(1'b0);
      wr(8'h1E, 8'h12);
      pinIs(1'b1);
    end
    $display("live source test done");
    tally_and_finish();
  end
endmodule : tb_led_fault_flags_and_pin_mask
